// File: charger_consts.svh
// Constants for the charger supervision block
`ifndef CHARGER_CONSTS_SVH
`define CHARGER_CONSTS_SVH

// ----------------------------------------
// Clock and timer base
// ----------------------------------------
`define SYS_CLK_HZ        20000000
`define MINUTE_S          60
`define TMO_CNT_W         9
`define DIV_W             31

// ----------------------------------------
// Timeout selection
// ----------------------------------------
`define TMO_SEL_CODE0     2'h0
`define TMO_SEL_CODE1     2'h1
`define TMO_SEL_CODE2     2'h2
`define TMO_SEL_DISABLED  2'h3
`define PRE_TMO_CODE0_MIN 9'h028
`define PRE_TMO_CODE1_MIN 9'h03c
`define PRE_TMO_CODE2_MIN 9'h050
`define TOT_TMO_CODE0_HR  9'h003
`define TOT_TMO_CODE1_HR  9'h004
`define TOT_TMO_CODE2_HR  9'h005
`define MIN_PER_HR        9'h03c

// ----------------------------------------
// Thermistor window, set by the analog comparators
// ----------------------------------------
`define NTC_HOT_MV        500
`define NTC_COLD_MV       2510

`endif

// File: charger_pkg.sv
// Types and shared decode for the charger supervision block
`include "charger_consts.svh"

package charger_pkg;

	typedef enum logic [2:0] {
		ST_SUSPEND,
		ST_PRECOND,
		ST_FAST,
		ST_TOPOFF,
		ST_EOC,
		ST_TEMP_FAULT,
		ST_TMO_FAULT
	} chg_state_t;

	typedef struct packed {
		logic [`TMO_CNT_W-1:0] minutes;
		logic                  done;
		logic                  expired;
	} tmr_state_t;

	typedef struct packed {
		logic              hot_s1;
		logic              cold_s1;
		logic              hot_s2;
		logic              cold_s2;
		logic              in_range;
		chg_state_t        state;
		logic [`DIV_W-1:0] div;
		logic              tick;
		logic              ind_oe;
		logic              temp_flag;
		logic              timer_flag;
	} core_state_t;

	function automatic logic [`TMO_CNT_W-1:0] timeout_limit(input logic [1:0] sel, input logic is_total);
		logic [`TMO_CNT_W-1:0] hrs;
		hrs = `TOT_TMO_CODE0_HR;
		timeout_limit = `PRE_TMO_CODE0_MIN;
		unique case (sel)
			`TMO_SEL_CODE1: begin
				hrs = `TOT_TMO_CODE1_HR;
				timeout_limit = `PRE_TMO_CODE1_MIN;
			end
			`TMO_SEL_CODE2: begin
				hrs = `TOT_TMO_CODE2_HR;
				timeout_limit = `PRE_TMO_CODE2_MIN;
			end
			default: ;
		endcase
		if (is_total) begin
			timeout_limit = `TMO_CNT_W'(hrs * `MIN_PER_HR);
		end
	endfunction

endpackage

// File: charger_timer_if.sv
// Link between the supervision core and one safety timer
`timescale 1ns/1ns

interface charger_timer_if;
	logic       tick;
	logic       run;
	logic       is_total;
	logic [1:0] sel;
	logic       expired;

	modport ctrl (output tick, output run, output is_total, output sel, input expired);
	modport tmr (input tick, input run, input is_total, input sel, output expired);
endinterface

// File: charger_safety_timer.sv
// Minute-based safety timer with selectable period
`timescale 1ns/1ns
`include "charger_consts.svh"

module charger_safety_timer (
	input  wire logic       sys_clk,
	input  wire logic       rst,
	charger_timer_if.tmr    t
);

	charger_pkg::tmr_state_t r;
	charger_pkg::tmr_state_t n;
	logic [`TMO_CNT_W-1:0]   limit;

	assign limit     = charger_pkg::timeout_limit(t.sel, t.is_total);
	assign t.expired = r.expired;

	always_comb begin
		n = r;
		n.expired = 1'b0;
		if (!t.run) begin
			n.minutes = '0;
			n.done    = 1'b0;
		end else if (t.tick && !r.done && t.sel != `TMO_SEL_DISABLED) begin
			n.minutes = r.minutes + `TMO_CNT_W'(1);
			if (n.minutes == limit) begin
				n.done    = 1'b1;
				n.expired = 1'b1;
			end
		end
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			r <= '0;
		end else begin
			r <= n;
		end
	end

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	property p_expire_at_limit;
		@(posedge sys_clk) disable iff (rst)
		(t.run && t.tick && !r.done && t.sel != `TMO_SEL_DISABLED && r.minutes + `TMO_CNT_W'(1) == limit)
		|=> r.expired;
	endproperty
	a_expire_at_limit: assert property (p_expire_at_limit) else $error("timer missed its period");

	property p_disabled_silent;
		@(posedge sys_clk) disable iff (rst)
		(t.sel == `TMO_SEL_DISABLED) [*2] |-> !r.expired;
	endproperty
	a_disabled_silent: assert property (p_disabled_silent) else $error("disabled timer expired");

endmodule

// File: charger_timer_temp_status.sv
// Charger supervision: safety timers, status pin, thermistor events
`timescale 1ns/1ns
`include "charger_consts.svh"

module charger_timer_temp_status #(
	parameter int MINUTE_CYCLES = `MINUTE_S * `SYS_CLK_HZ
) (
	input  wire logic       sys_clk,
	input  wire logic       rst,
	input  wire logic [1:0] precond_timeout_sel,
	input  wire logic [1:0] total_timeout_sel,
	input  wire logic       charge_en,
	input  wire logic       supply_ok,
	input  wire logic       vbat_above_precond,
	input  wire logic       vbat_at_term,
	input  wire logic       eoc_current,
	input  wire logic       vbat_recharge,
	input  wire logic       battery_ntc_sense_hot,
	input  wire logic       battery_ntc_sense_cold,
	input  wire logic       temp_exit_irq_en,
	input  wire logic       temp_return_irq_en,
	input  wire logic       temp_event_en,
	input  wire logic       precond_expiry_irq_en,
	input  wire logic       total_expiry_irq_en,
	input  wire logic       timer_event_en,
	input  wire logic       temp_event_rd,
	input  wire logic       timer_event_rd,
	output logic            charge_indicator_n_o,
	output logic            charge_indicator_n_oe,
	output logic            temp_in_range,
	output logic            temp_event_flag,
	output logic            timer_event_flag,
	output logic [2:0]      charge_state,
	output logic            chg_irq
);

	charger_pkg::core_state_t r;
	charger_pkg::core_state_t n;
	logic                     temp_set;
	logic                     timer_set;
	logic                     run_ok;

	charger_timer_if pre_if ();
	charger_timer_if tot_if ();

	// ----------------------------------------
	// Safety timers
	// ----------------------------------------
	assign pre_if.tick     = r.tick;
	assign pre_if.run      = (r.state == charger_pkg::ST_PRECOND);
	assign pre_if.is_total = 1'b0;
	assign pre_if.sel      = precond_timeout_sel;
	assign tot_if.tick     = r.tick;
	assign tot_if.run      = (r.state == charger_pkg::ST_FAST) || (r.state == charger_pkg::ST_TOPOFF);
	assign tot_if.is_total = 1'b1;
	assign tot_if.sel      = total_timeout_sel;

	charger_safety_timer u_pre_timer (
		.sys_clk (sys_clk),
		.rst     (rst),
		.t       (pre_if.tmr)
	);

	charger_safety_timer u_tot_timer (
		.sys_clk (sys_clk),
		.rst     (rst),
		.t       (tot_if.tmr)
	);

	// ----------------------------------------
	// Next state
	// ----------------------------------------
	assign run_ok = charge_en && supply_ok;

	always_comb begin
		n = r;
		// Only the second stage is looked at by logic
		n.hot_s1   = battery_ntc_sense_hot;
		n.cold_s1  = battery_ntc_sense_cold;
		n.hot_s2   = r.hot_s1;
		n.cold_s2  = r.cold_s1;
		n.in_range = !r.hot_s2 && !r.cold_s2;

		n.tick = 1'b0;
		if (r.div == `DIV_W'(MINUTE_CYCLES - 1)) begin
			n.div  = '0;
			n.tick = 1'b1;
		end else begin
			n.div = r.div + `DIV_W'(1);
		end

		if (!run_ok) begin
			n.state = charger_pkg::ST_SUSPEND;
		end else if (!r.in_range && r.state != charger_pkg::ST_TMO_FAULT) begin
			n.state = charger_pkg::ST_TEMP_FAULT;
		end else begin
			unique case (r.state)
				charger_pkg::ST_SUSPEND: n.state = charger_pkg::ST_PRECOND;
				charger_pkg::ST_TEMP_FAULT: n.state = charger_pkg::ST_PRECOND;
				charger_pkg::ST_PRECOND: begin
					// Timeout wins so a dying cell is never pushed on
					if (pre_if.expired) begin
						n.state = charger_pkg::ST_TMO_FAULT;
					end else if (vbat_above_precond) begin
						n.state = charger_pkg::ST_FAST;
					end
				end
				charger_pkg::ST_FAST: begin
					if (tot_if.expired) begin
						n.state = charger_pkg::ST_EOC;
					end else if (vbat_at_term) begin
						n.state = charger_pkg::ST_TOPOFF;
					end
				end
				charger_pkg::ST_TOPOFF: begin
					if (tot_if.expired || eoc_current) begin
						n.state = charger_pkg::ST_EOC;
					end
				end
				charger_pkg::ST_EOC: begin
					if (vbat_recharge) begin
						n.state = charger_pkg::ST_PRECOND;
					end
				end
				charger_pkg::ST_TMO_FAULT: n.state = charger_pkg::ST_TMO_FAULT;
				default: n.state = charger_pkg::ST_SUSPEND;
			endcase
		end

		n.ind_oe = (n.state == charger_pkg::ST_PRECOND) || (n.state == charger_pkg::ST_FAST) ||
			(n.state == charger_pkg::ST_TOPOFF);

		// Set beats a read in the same cycle so no event is lost
		n.temp_flag  = temp_set || (r.temp_flag && !temp_event_rd);
		n.timer_flag = timer_set || (r.timer_flag && !timer_event_rd);
	end

	always_comb begin
		// Next in-range value taken from the sync stage, not from n, to keep the loop open
		temp_set = temp_event_en && (
			(r.in_range && (r.hot_s2 || r.cold_s2) && temp_exit_irq_en) ||
			(!r.in_range && !r.hot_s2 && !r.cold_s2 && temp_return_irq_en));
		timer_set = timer_event_en && (
			(pre_if.expired && precond_expiry_irq_en) ||
			(tot_if.expired && total_expiry_irq_en));
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			r <= '0;
		end else begin
			r <= n;
		end
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	assign charge_indicator_n_o  = 1'b0;
	assign charge_indicator_n_oe = r.ind_oe;
	assign temp_in_range         = r.in_range;
	assign temp_event_flag       = r.temp_flag;
	assign timer_event_flag      = r.timer_flag;
	assign charge_state          = r.state;
	assign chg_irq               = (r.temp_flag && temp_event_en) || (r.timer_flag && timer_event_en);

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	default clocking @(posedge sys_clk); endclocking
	default disable iff (rst);

	sequence s_active;
		r.state inside {charger_pkg::ST_PRECOND, charger_pkg::ST_FAST, charger_pkg::ST_TOPOFF};
	endsequence
	sequence s_temp_exit;
		$fell(r.in_range) && $past(temp_exit_irq_en && temp_event_en);
	endsequence
	sequence s_temp_return;
		$rose(r.in_range) && $past(temp_return_irq_en && temp_event_en);
	endsequence
	sequence s_pre_expiry;
		r.state == charger_pkg::ST_PRECOND && pre_if.expired && run_ok && r.in_range;
	endsequence

	property p_ind_active;
		s_active |-> charge_indicator_n_oe;
	endproperty
	a_ind_active: assert property (p_ind_active) else $error("indicator not sinking while charging");

	property p_ind_idle;
		!(r.state inside {charger_pkg::ST_PRECOND, charger_pkg::ST_FAST, charger_pkg::ST_TOPOFF})
		|-> !charge_indicator_n_oe;
	endproperty
	a_ind_idle: assert property (p_ind_idle) else $error("indicator driven while not charging");

	property p_temp_suspend;
		(run_ok && !r.in_range && r.state != charger_pkg::ST_TMO_FAULT)
		|=> r.state == charger_pkg::ST_TEMP_FAULT && !charge_indicator_n_oe;
	endproperty
	a_temp_suspend: assert property (p_temp_suspend) else $error("charging not halted on temperature");

	property p_exit_irq;
		s_temp_exit |-> temp_event_flag ##0 chg_irq || !temp_event_en;
	endproperty
	a_exit_irq: assert property (p_exit_irq) else $error("no event on temperature exit");

	property p_return_irq;
		s_temp_return |-> temp_event_flag;
	endproperty
	a_return_irq: assert property (p_return_irq) else $error("no event on temperature return");

	property p_live_bit;
		// Pipeline holds reset values for the first three edges
		!$past(rst, 3) |-> temp_in_range == $past(!battery_ntc_sense_hot && !battery_ntc_sense_cold, 3);
	endproperty
	a_live_bit: assert property (p_live_bit) else $error("live temperature bit wrong");

	property p_read_clear;
		(temp_event_rd && !temp_set) |=> !temp_event_flag;
	endproperty
	a_read_clear: assert property (p_read_clear) else $error("temperature flag not cleared by read");

	property p_pre_fault;
		s_pre_expiry |=> r.state == charger_pkg::ST_TMO_FAULT;
	endproperty
	a_pre_fault: assert property (p_pre_fault) else $error("no timeout fault on precondition expiry");

	property p_timer_irq;
		(s_pre_expiry and (precond_expiry_irq_en && timer_event_en)) |=> timer_event_flag && chg_irq;
	endproperty
	a_timer_irq: assert property (p_timer_irq) else $error("no timer event on precondition expiry");

	property p_irq_hold;
		(temp_event_flag && temp_event_en && !temp_event_rd) ##1 temp_event_en |-> chg_irq;
	endproperty
	a_irq_hold: assert property (p_irq_hold) else $error("interrupt dropped while flag set");

endmodule

// File: host_poller.sv
// Host model that polls and clears the charger event flags
`timescale 1ns/1ns

module host_poller (
	input  wire logic sys_clk,
	input  wire logic rst,
	input  wire logic temp_req,
	input  wire logic timer_req,
	input  wire logic temp_event_flag,
	input  wire logic timer_event_flag,
	output logic      temp_event_rd,
	output logic      timer_event_rd,
	output logic      temp_seen,
	output logic      timer_seen
);
	// ----------------------------------------
	// Read strobes
	// ----------------------------------------
	// One-cycle strobe; value captured on the edge that clears the flag
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			temp_event_rd <= 1'b0;
			timer_event_rd <= 1'b0;
			temp_seen <= 1'b0;
			timer_seen <= 1'b0;
		end else begin
			temp_event_rd <= temp_req;
			timer_event_rd <= timer_req;
			if (temp_event_rd) begin
				temp_seen <= temp_event_flag;
			end
			if (timer_event_rd) begin
				timer_seen <= timer_event_flag;
			end
		end
	end
endmodule

// File: tb_top.sv
// Self-checking testbench for the charger supervision block
`timescale 1ns/1ns

module tb_top;
	localparam int MC = 4;
	logic       sys_clk = 1'b0;
	logic       rst = 1'b1;
	logic [1:0] pre_sel = 2'h3;
	logic [1:0] tot_sel = 2'h3;
	logic       en = 0, sok = 0, vpre = 0, vterm = 0, veoc = 0, vrech = 0, hot = 0, cold = 0;
	logic       t_exit = 0, t_ret = 0, t_ev = 0, p_en = 0, tot_en = 0, tm_ev = 0;
	logic       temp_req = 0, timer_req = 0;
	logic       temp_rd, timer_rd, temp_seen, timer_seen;
	logic       ind_o, ind_oe, in_rng, t_flag, tm_flag, irq;
	logic [2:0] st;
	logic       v;
	int         n_mismatch = 0, comparisons = 0, cyc = 0, n = 0, mins = 0;

	always #25 sys_clk = ~sys_clk;

	charger_timer_temp_status #(.MINUTE_CYCLES(MC)) u_dut (
		.sys_clk(sys_clk), .rst(rst), .precond_timeout_sel(pre_sel), .total_timeout_sel(tot_sel),
		.charge_en(en), .supply_ok(sok), .vbat_above_precond(vpre), .vbat_at_term(vterm),
		.eoc_current(veoc), .vbat_recharge(vrech), .battery_ntc_sense_hot(hot),
		.battery_ntc_sense_cold(cold), .temp_exit_irq_en(t_exit), .temp_return_irq_en(t_ret),
		.temp_event_en(t_ev), .precond_expiry_irq_en(p_en), .total_expiry_irq_en(tot_en),
		.timer_event_en(tm_ev), .temp_event_rd(temp_rd), .timer_event_rd(timer_rd),
		.charge_indicator_n_o(ind_o), .charge_indicator_n_oe(ind_oe), .temp_in_range(in_rng),
		.temp_event_flag(t_flag), .timer_event_flag(tm_flag), .charge_state(st), .chg_irq(irq));

	host_poller u_host (
		.sys_clk(sys_clk), .rst(rst), .temp_req(temp_req), .timer_req(timer_req),
		.temp_event_flag(t_flag), .timer_event_flag(tm_flag), .temp_event_rd(temp_rd),
		.timer_event_rd(timer_rd), .temp_seen(temp_seen), .timer_seen(timer_seen));

	// ----------------------------------------
	// Shared tasks
	// ----------------------------------------
	task automatic complete_run;
		$display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
		if (n_mismatch == 0 && comparisons > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask

	task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string what);
		comparisons++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("wrong value at %0t: %s got %h expected %h", $time, what, seen, exp);
		end
	endtask

	task automatic wait_state(input logic [2:0] exp, input int max);
		n = 0;
		while (st !== exp && n < max) begin
			@(negedge sys_clk);
			n++;
		end
	endtask

	// Flag value is what the host captured on the clearing edge
	task automatic host_read(input bit timer);
		@(posedge sys_clk);
		if (timer) timer_req <= 1'b1;
		else temp_req <= 1'b1;
		@(posedge sys_clk);
		timer_req <= 1'b0;
		temp_req <= 1'b0;
		@(posedge sys_clk);
		@(negedge sys_clk);
		v = timer ? timer_seen : temp_seen;
	endtask

	task automatic restart;
		@(posedge sys_clk);
		en <= 1'b0;
		@(posedge sys_clk);
		en <= 1'b1;
		wait_state(3'h0, 4);
		check({st, ind_oe}, 4'h0, "suspend released");
	endtask

	always @(posedge sys_clk) begin
		cyc++;
		if (cyc == 10000) begin
			n_mismatch++;
			complete_run();
		end
	end

	// ----------------------------------------
	// Test sequence
	// ----------------------------------------
	initial begin
		repeat (12) @(posedge sys_clk);
		rst <= 1'b0;
		@(negedge sys_clk);
		check(st, 3'h0, "reset state");
		check({1'b0, ind_o, ind_oe}, 3'h0, "reset indicator");
		@(posedge sys_clk);
		{en, sok, t_exit, t_ret, t_ev, p_en, tm_ev, tot_en} <= 8'hff;
		wait_state(3'h1, 12);
		check(st, 3'h1, "precond");
		check(ind_oe, 1'b1, "sink precond");
		check(in_rng, 1'b1, "in range");
		// Inputs driven at an edge are seen by the design at the next one
		@(posedge sys_clk) vpre <= 1'b1;
		@(negedge sys_clk);
		@(negedge sys_clk) check({ind_oe, st[1:0]}, 3'h6, "fast sink");
		@(posedge sys_clk) vterm <= 1'b1;
		@(negedge sys_clk);
		@(negedge sys_clk) check({ind_oe, st[1:0]}, 3'h7, "topoff sink");
		@(posedge sys_clk) veoc <= 1'b1;
		@(negedge sys_clk);
		@(negedge sys_clk) check(st, 3'h4, "eoc");
		check(ind_oe, 1'b0, "eoc released");
		@(posedge sys_clk);
		{veoc, vpre, vterm, vrech} <= 4'h1;
		@(negedge sys_clk);
		@(negedge sys_clk) check(st, 3'h1, "recharge");
		@(posedge sys_clk);
		vrech <= 1'b0;
		hot <= 1'b1;
		wait_state(3'h5, 8);
		check(st, 3'h5, "hot suspends");
		check({in_rng, ind_oe}, 3'h0, "out of range");
		check({t_flag, irq}, 3'h3, "exit event");
		host_read(0);
		check({v, t_flag, irq}, 3'h4, "read clears");
		@(posedge sys_clk) hot <= 1'b0;
		wait_state(3'h1, 8);
		check({in_rng, t_flag}, 3'h3, "return event");
		host_read(0);
		check(t_flag, 1'b0, "read clears");
		// Event enable off: no flag on a cold exit
		@(posedge sys_clk);
		t_ev <= 1'b0;
		cold <= 1'b1;
		wait_state(3'h5, 8);
		check({st, t_flag, irq}, 3'h5 << 2, "cold masked");
		@(posedge sys_clk);
		cold <= 1'b0;
		t_ev <= 1'b1;
		for (int s = 0; s < 4; s++) begin
			mins = 40 + 20 * s;
			@(posedge sys_clk) pre_sel <= 2'(s);
			restart();
			wait_state(3'h1, 8);
			wait_state(3'h6, 90 * MC);
			if (s < 3) begin
				check(3'(n >= (mins - 1) * MC && n <= mins * MC + 2), 3'h1, "precond period");
				check({irq, tm_flag, ind_oe}, 3'h6, "timer event");
				host_read(1);
				check({v, tm_flag}, 3'h2, "timer read");
			end else begin
				check(st, 3'h1, "precond disabled");
			end
		end
		@(posedge sys_clk);
		vpre <= 1'b1;
		for (int s = 0; s < 4; s++) begin
			mins = 60 * (3 + s);
			@(posedge sys_clk) tot_sel <= 2'(s);
			restart();
			wait_state(3'h2, 12);
			wait_state(3'h4, 310 * MC);
			if (s < 3) begin
				check(3'(n >= (mins - 1) * MC && n <= mins * MC + 2), 3'h1, "total period");
			end else begin
				check(st, 3'h2, "total disabled");
			end
		end
		complete_run();
	end
endmodule
